// ---- clock_loss_timer.v ----
// one-shot timeout on a monitored clock that stops toggling
`timescale 1ns/1ns
`default_nettype none
`include "reset_source_defines.vh"

module clock_loss_timer #(
    parameter CNT_W = `RSC_CLK_LOSS_W,
    parameter [CNT_W-1:0] LIMIT = `RSC_CLK_LOSS_CYC
) (
    input wire clock,
    input wire sys_rst,
    input wire ce,
    input wire armed,
    input wire clockSense,
    output reg timeout
);

    reg senseLast_r;
    reg [CNT_W-1:0] count_r;
    wire senseEdge;

    assign senseEdge = clockSense ^ senseLast_r;

    always @(posedge clock) begin
        if (sys_rst) begin
            senseLast_r <= 1'b0;
            count_r <= {CNT_W{1'b0}};
            timeout <= 1'b0;
        end else if (ce) begin
            senseLast_r <= clockSense;
            timeout <= 1'b0;
            // any level change restarts the one-shot
            if (!armed || senseEdge) begin
                count_r <= {CNT_W{1'b0}};
            end else if (count_r == LIMIT - 1'b1) begin
                count_r <= {CNT_W{1'b0}};
                timeout <= 1'b1;
            end else begin
                count_r <= count_r + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- reset_event_sources.sv ----
// behavioural reset event sources and monitored clock
`timescale 1ns/1ns
`default_nettype none
module reset_event_sources (
    input wire logic clock,
    input wire logic [6:0] evt,
    output wire logic rtcEvent, flashFault, comparatorTrip, watchdogOverflow,
    output wire logic rstPinN, supplyFail,
    output var logic clockSense
);
    assign {rtcEvent, flashFault, comparatorTrip, watchdogOverflow} = evt[5:2];
    assign rstPinN = !evt[1];
    assign supplyFail = evt[0];
    initial clockSense = 1'b0;
    // monitored clock stops only while bit 6 asks
    always @(posedge clock) begin
        #1;
        if (!evt[6]) clockSense = !clockSense;
    end
endmodule
`default_nettype wire

// ---- reset_source_capture.v ----
// reset cause capture, source enables and system reset sequencing
`timescale 1ns/1ns
`default_nettype none
`include "reset_source_defines.vh"

module reset_source_capture #(
    parameter [`RSC_CLK_LOSS_W-1:0] CLK_LOSS_CYCLES = `RSC_CLK_LOSS_CYC,
    parameter [7:0] HOLD_CYCLES = `RSC_HOLD_CYC
) (
    input wire clock,
    input wire sys_rst,
    input wire ce,
    input wire [7:0] sfrPage,
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire sfrRead,
    input wire sfrRmw,
    input wire [7:0] sfrWdata,
    output reg [7:0] sfrRdata,
    input wire rtcEvent,
    input wire flashFault,
    input wire comparatorTrip,
    input wire watchdogOverflow,
    input wire rstPinN,
    input wire supplyFail,
    input wire clockSense,
    input wire lowPowerMode,
    output reg systemResetOut,
    output reg clockLossArmed
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    function regHit;
        input [7:0] page;
        input [7:0] addr;
        begin
            regHit = (page == `RSC_SFR_PAGE) && (addr == `RSC_SFR_ADDR);
        end
    endfunction

    reg [1:0] state_r;
    reg [7:0] holdCnt_r;
    reg [7:0] cause_r;
    reg [7:0] flags_r;
    reg rtcEn_r;
    reg cmpEn_r;
    reg clkLossEn_r;
    reg supplyEn_r;

    wire running;
    wire wrHit;
    wire rdHit;
    wire clockTimeout;
    wire holdSource;
    wire holdDone;
    wire [7:0] trig;
    wire [7:0] latchView;

    assign running = (state_r == `RSC_ST_RUN);
    assign wrHit = sfrWrite && regHit(sfrPage, sfrAddr) && running;
    assign rdHit = sfrRead && regHit(sfrPage, sfrAddr);

    ////////////////////////////////////////////////////////////////////////
    // reset sources

    assign trig[`RSC_BIT_RTC] = rtcEvent && rtcEn_r;
    assign trig[`RSC_BIT_FLASH] = flashFault;
    assign trig[`RSC_BIT_CMP] = comparatorTrip && cmpEn_r;
    assign trig[`RSC_BIT_SWFORCE] = wrHit && sfrWdata[`RSC_BIT_SWFORCE];
    assign trig[`RSC_BIT_WDOG] = watchdogOverflow;
    assign trig[`RSC_BIT_CLKLOSS] = clockTimeout;
    assign trig[`RSC_BIT_POWER] = supplyFail && supplyEn_r;
    assign trig[`RSC_BIT_PIN] = !rstPinN;

    // level sources keep the reset asserted while they last
    assign holdSource = !rstPinN || (supplyFail && supplyEn_r);
    assign holdDone = (holdCnt_r == HOLD_CYCLES - 8'h01) && !holdSource;

    ////////////////////////////////////////////////////////////////////////
    // clock-loss detector

    always @(posedge clock) begin
        if (sys_rst) begin
            clockLossArmed <= 1'b0;
        end else if (ce) begin
            // enable kept in clkLossEn_r, so leaving low power restores it
            clockLossArmed <= clkLossEn_r && !lowPowerMode && running && !trig[`RSC_BIT_CLKLOSS];
        end
    end

    clock_loss_timer #(
        .CNT_W(`RSC_CLK_LOSS_W),
        .LIMIT(CLK_LOSS_CYCLES)
    ) u_clock_loss_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .armed(clockLossArmed),
        .clockSense(clockSense),
        .timeout(clockTimeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer

    always @(posedge clock) begin
        if (sys_rst) begin
            state_r <= `RSC_ST_RUN;
            holdCnt_r <= 8'h00;
            systemResetOut <= 1'b0;
        end else if (ce) begin
            case (state_r)
                `RSC_ST_RUN: begin
                    holdCnt_r <= 8'h00;
                    if (|trig) begin
                        state_r <= `RSC_ST_HOLD;
                        systemResetOut <= 1'b1;
                    end
                end
                `RSC_ST_HOLD: begin
                    if (holdSource) begin
                        holdCnt_r <= 8'h00;
                    end else if (holdDone) begin
                        holdCnt_r <= 8'h00;
                        state_r <= `RSC_ST_RUN;
                        systemResetOut <= 1'b0;
                    end else begin
                        holdCnt_r <= holdCnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= `RSC_ST_RUN;
                    holdCnt_r <= 8'h00;
                    systemResetOut <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cause capture

    always @(posedge clock) begin
        if (sys_rst) begin
            cause_r <= 8'h00;
        end else if (ce) begin
            if (running) begin
                cause_r <= trig;
            end else begin
                // sources firing during the hold add to the cause
                cause_r <= cause_r | trig;
            end
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            flags_r <= `RSC_FLAGS_POWER_ON;
        end else if (ce) begin
            // flags load only at release
            if (!running && holdDone) begin
                flags_r <= cause_r | trig;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source enables

    always @(posedge clock) begin
        if (sys_rst) begin
            rtcEn_r <= `RSC_RTC_EN_RST;
            cmpEn_r <= `RSC_CMP_EN_RST;
            clkLossEn_r <= `RSC_CLKLOSS_EN_RST;
            supplyEn_r <= `RSC_SUPPLY_EN_RST;
        end else if (ce) begin
            if (!running && holdDone) begin
                rtcEn_r <= `RSC_RTC_EN_RST;
                cmpEn_r <= `RSC_CMP_EN_RST;
                clkLossEn_r <= `RSC_CLKLOSS_EN_RST;
                supplyEn_r <= `RSC_SUPPLY_EN_RST;
            end else if (wrHit && !sfrWdata[`RSC_BIT_SWFORCE]) begin
                rtcEn_r <= sfrWdata[`RSC_BIT_RTC];
                cmpEn_r <= sfrWdata[`RSC_BIT_CMP];
                clkLossEn_r <= sfrWdata[`RSC_BIT_CLKLOSS];
                supplyEn_r <= sfrWdata[`RSC_BIT_POWER];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback

    // latch view for read-modify-write: enables, force bit and flags as 0
    assign latchView = {
        rtcEn_r,
        1'b0,
        cmpEn_r,
        1'b0,
        1'b0,
        clkLossEn_r,
        supplyEn_r,
        1'b0
    };

    always @(posedge clock) begin
        if (sys_rst) begin
            sfrRdata <= 8'h00;
        end else if (ce) begin
            if (rdHit) begin
                if (sfrRmw) begin
                    sfrRdata <= latchView;
                end else begin
                    sfrRdata <= flags_r;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- reset_source_capture_sva.sv ----
// assertions on the reset cause capture ports
`timescale 1ns/1ns
`default_nettype none
module reset_source_capture_sva #(
    parameter CLK_LOSS_CYCLES = 5000,
    parameter HOLD_CYCLES = 16
) (
    input wire logic clock, sys_rst, ce,
    input wire logic [7:0] sfrPage, sfrAddr, sfrWdata, sfrRdata,
    input wire logic sfrWrite, sfrRead, sfrRmw,
    input wire logic rtcEvent, flashFault, comparatorTrip, watchdogOverflow,
    input wire logic rstPinN, supplyFail, clockSense, lowPowerMode,
    input wire logic systemResetOut, clockLossArmed
);
    logic hit;
    logic sense_r = 1'b0;
    int highCnt_r = 0;
    int stuckCnt_r = 0;
    assign hit = sfrPage == 8'h00 && sfrAddr == 8'hef;
    // reset high time and cycles of an unchanged clock
    always @(posedge clock) begin
        sense_r <= clockSense;
        highCnt_r <= systemResetOut ? highCnt_r + 1 : 0;
        stuckCnt_r <= (clockLossArmed && clockSense == sense_r) ? stuckCnt_r + 1 : 0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_sw; ce && sfrWrite && hit && sfrWdata[4] && !systemResetOut
        |=> systemResetOut; endproperty
    a_sw: assert property (p_sw) else $error("no software reset");
    property p_pin; ce && !rstPinN && !systemResetOut |=> systemResetOut; endproperty
    a_pin: assert property (p_pin) else $error("no pin reset");
    property p_hold; $fell(systemResetOut) |-> highCnt_r >= HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("reset too short");
    property p_rmw; ce && sfrRead && sfrRmw && hit |=> (sfrRdata & 8'h59) == 8'h00; endproperty
    a_rmw: assert property (p_rmw) else $error("bad modify view");
    property p_rdHold; !(ce && sfrRead && hit) |=> $stable(sfrRdata); endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved");
    property p_lowPwr; ce && lowPowerMode |=> !clockLossArmed; endproperty
    a_lowPwr: assert property (p_lowPwr) else $error("armed in low power");
    property p_disarm; systemResetOut && $past(systemResetOut) |-> !clockLossArmed; endproperty
    a_disarm: assert property (p_disarm) else $error("armed in hold");
    property p_loss; stuckCnt_r == CLK_LOSS_CYCLES + 1 |-> systemResetOut; endproperty
    a_loss: assert property (p_loss) else $error("no clock loss reset");
endmodule
bind reset_source_capture reset_source_capture_sva #(.CLK_LOSS_CYCLES(CLK_LOSS_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) u_sva (.clock, .sys_rst, .ce, .sfrPage, .sfrAddr, .sfrWdata,
    .sfrRdata, .sfrWrite, .sfrRead, .sfrRmw, .rtcEvent, .flashFault, .comparatorTrip,
    .watchdogOverflow, .rstPinN, .supplyFail, .clockSense, .lowPowerMode, .systemResetOut,
    .clockLossArmed);
`default_nettype wire

// ---- reset_source_capture_tb.sv ----
// self-checking bench for the reset cause capture block
`timescale 1ns/1ns
`default_nettype none
`include "reset_source_defines.vh"
module reset_source_capture_tb;
    logic clock = 0, sys_rst = 1, sfrWrite = 0, sfrRead = 0, sfrRmw = 0, lowPowerMode = 0;
    logic ce = 1;
    logic [7:0] sfrPage = 8'h00, sfrAddr = 8'hef, sfrWdata = 8'h00;
    logic [6:0] evt = 7'h00;
    wire logic [7:0] sfrRdata;
    wire logic rtcEvent, flashFault, comparatorTrip, watchdogOverflow, rstPinN, supplyFail;
    wire logic clockSense, systemResetOut, clockLossArmed;
    int n_mismatch = 0, check_count = 0;
    // write data, source events {stall,rtc,flash,cmp,wdog,pin,supply}, flags read after
    logic [22:0] rows [0:7] = '{{8'ha0, 7'h20, 8'h80}, {8'h00, 7'h10, 8'h40},
        {8'h20, 7'h08, 8'h20}, {8'h00, 7'h04, 8'h08}, {8'h00, 7'h02, 8'h01},
        {8'h02, 7'h01, 8'h02}, {8'h10, 7'h00, 8'h10}, {8'h04, 7'h40, 8'h04}};
    reset_source_capture #(.CLK_LOSS_CYCLES(13'h0014), .HOLD_CYCLES(8'h04)) u_dut (.clock,
        .sys_rst, .ce, .sfrPage, .sfrAddr, .sfrWrite, .sfrRead, .sfrRmw,
        .sfrWdata, .sfrRdata, .rtcEvent, .flashFault, .comparatorTrip, .watchdogOverflow,
        .rstPinN, .supplyFail, .clockSense, .lowPowerMode, .systemResetOut, .clockLossArmed);
    reset_event_sources u_src (.clock, .evt, .rtcEvent, .flashFault, .comparatorTrip,
        .watchdogOverflow, .rstPinN, .supplyFail, .clockSense);
    initial forever #10 clock = !clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1;
        step;
        sfrWrite = 0;
    endtask
    task automatic rd(input logic m, input logic [7:0] e);
        logic [7:0] msk;
        // power flag set: other flag bits are not relied on
        msk = (!m && e[1]) ? 8'h02 : 8'hff;
        sfrAddr = 8'hef;
        sfrRead = 1;
        sfrRmw = m;
        step;
        sfrRead = 0;
        sfrRmw = 0;
        chk(sfrRdata & msk, e & msk);
    endtask
    task automatic waitRel;
        int i;
        logic seen;
        seen = 0;
        for (i = 0; i < 100; i++) begin
            seen |= systemResetOut;
            if (seen && !systemResetOut) break;
            step;
        end
        if (i == 100) begin
            n_mismatch++;
            print_verdict;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) step;
        sys_rst = 0;
        rd(0, 8'h02);
        foreach (rows[k]) begin
            wr(8'hef, rows[k][22:15]);
            evt = rows[k][14:8];
            step;
            evt = evt & 7'h40;
            waitRel;
            evt = 0;
            rd(0, rows[k][7:0]);
        end
        wr(8'hef, 8'h00);
        evt = 7'h29;
        step;
        evt = 0;
        repeat (3) step;
        chk({7'h0, systemResetOut}, 8'h00);
        wr(8'hee, 8'h10);
        step;
        chk({7'h0, systemResetOut}, 8'h00);
        sfrPage = 8'h01;
        wr(8'hef, 8'h10);
        step;
        chk({7'h0, systemResetOut}, 8'h00);
        sfrPage = 8'h00;
        // clock enable low freezes writes, reads and the sequencer
        ce = 0;
        wr(8'hef, 8'h10);
        rd(1, 8'h04);
        chk({7'h0, systemResetOut}, 8'h00);
        ce = 1;
        wr(8'hef, 8'hed);
        rd(1, 8'ha4);
        step;
        rd(0, 8'h04);
        chk({7'h0, clockLossArmed}, 8'h01);
        lowPowerMode = 1;
        evt = 7'h40;
        repeat (30) step;
        chk({7'h0, systemResetOut | clockLossArmed}, 8'h00);
        lowPowerMode = 0;
        waitRel;
        evt = 0;
        rd(0, 8'h04);
        wr(8'hef, 8'h84);
        step;
        chk({7'h0, clockLossArmed}, 8'h01);
        sys_rst = 1;
        step;
        sys_rst = 0;
        rd(1, 8'h02);
        chk({6'h0, systemResetOut, clockLossArmed}, 8'h00);
        step;
        rd(0, 8'h02);
        print_verdict;
    end
endmodule
`default_nettype wire

// ---- reset_source_defines.vh ----
// constants for the reset cause capture and source enable block
`ifndef RESET_SOURCE_DEFINES_VH
`define RESET_SOURCE_DEFINES_VH

// register location on the special-function-register bus
`define RSC_SFR_PAGE 8'h00
`define RSC_SFR_ADDR 8'hef

// bit positions in reset_cause_and_enable
`define RSC_BIT_RTC 7
`define RSC_BIT_FLASH 6
`define RSC_BIT_CMP 5
`define RSC_BIT_SWFORCE 4
`define RSC_BIT_WDOG 3
`define RSC_BIT_CLKLOSS 2
`define RSC_BIT_POWER 1
`define RSC_BIT_PIN 0

// flag value after power-on: only the power flag is set
`define RSC_FLAGS_POWER_ON 8'h02

// source enables after any reset
`define RSC_RTC_EN_RST 1'b0
`define RSC_CMP_EN_RST 1'b0
`define RSC_CLKLOSS_EN_RST 1'b0
`define RSC_SUPPLY_EN_RST 1'b1

// one-hot sequencer states
`define RSC_ST_RUN 2'b01
`define RSC_ST_HOLD 2'b10

// timing
`define RSC_CLK_FREQ_HZ 50000000
`define RSC_CLK_LOSS_US 100
// clock-loss limit in system clocks: 100 us at 50 MHz, sized for the counter
`define RSC_CLK_LOSS_CYC 13'h1388
`define RSC_CLK_LOSS_W 13
`define RSC_HOLD_CYC 8'h10

`endif
